// file: fmh_pkg.sv
// Constants and types shared by the flow meter host interface.
// Overview of operation
// - Synchronous output only transmits, never receives.
// - Configuration arrives only through the command port.
// - Push mode sends each result on both ports.
// - Get mode sends buffered value again and again while select is low.
// - Synchronous output is valid only while running.
// - Device alone toggles the serial clock.
// - Most significant bit first, data changes on rise.
// - Push mode frames sixteen bits with chip select.
// - Data output floats while not selected; here it floats only between frames, so a get-mode frame runs past deselect.
// - Commands end with line feed or return.
// - Finished command answers ok, then accepts more.
// - Keywords match regardless of letter case.
// - Run, halt and single measurement commands.
// - Output mode set P or G, queried.
// - Quantity set F or T, queried.
// - Resolution zero to seven, eight to fifteen bits.
// - Interval zero disables updates; default sixty seconds.
// - Temperature update lasts 45 ms, halting flow.
// - Command port 19200 baud 8N1, echoing.
// - Values are 16-bit signed two's complement.
// - Unknown keyword error 01, range error 03.
package fmh_pkg;
	localparam int CLK_HZ = 250_000_000;
	localparam int BAUD = 19200;
	localparam int BAUD_DIV = CLK_HZ / BAUD;
	localparam int UART_FRAME_BITS = 10;
	localparam int RX_STOP_BIT = 9;
	localparam int WORD_W = 16;
	localparam int WORD_BITS = 16;
	localparam int SLICE_MS = 5;
	localparam int SLICE_CYC = CLK_HZ / 1000 * SLICE_MS;
	localparam int TEMP_MS = 45;
	localparam int TEMP_CYC = CLK_HZ / 1000 * TEMP_MS;
	localparam logic [15:0] INT_DEFAULT = 16'h2EE0;
	localparam logic [2:0] RES_DEFAULT = 3'h4;
	localparam int INT_MAX = 65535;
	localparam int LINE_LEN = 12;
	localparam int RESP_LEN = 10;
	localparam int SLOTS = 10;
	localparam int USER_BYTES = 4;
	localparam int INT_ARG_POS = 4;
	localparam int WD_SLOT_POS = 5;
	localparam int WD_DATA_POS = 7;
	localparam int SCK_HALF = 4;
	localparam logic [7:0] CH_LF = 8'h0A;
	localparam logic [7:0] CH_CR = 8'h0D;
	localparam logic [7:0] CH_0 = 8'h30;
	localparam logic [7:0] CH_9 = 8'h39;
	localparam logic [7:0] CH_EQ = 8'h3D;
	localparam logic [7:0] CH_A_LO = 8'h61;
	localparam logic [7:0] CH_Z_LO = 8'h7A;
	localparam logic [7:0] CASE_BIT = 8'h20;
	localparam logic [7:0] ERR_NONE = 8'h00;
	localparam logic [7:0] ERR_CMD = 8'h31;
	localparam logic [7:0] ERR_RANGE = 8'h33;
	typedef enum logic {SPI_PUSH, SPI_GET} fmh_spi_mode_t;
	typedef enum logic {QTY_FLOW, QTY_TEMP} fmh_qty_t;
endpackage

// file: fmh_link_if.sv
// Interface carrying the result word and mode levels to the link domain.
interface fmh_link_if;
	logic [15:0] word;
	logic wordToggle;
	logic pushMode;
	logic running;
	modport core (output word, wordToggle, pushMode, running);
	modport link (input word, wordToggle, pushMode, running);
endinterface

// file: fmh_sync.sv
// Two flip-flop synchroniser for levels entering a clock domain.
module fmh_sync #(
	parameter int W = 1
) (
	// Destination clock.
	input wire logic clk,
	// Asynchronous levels in, synchronised levels out.
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	// The first stage is read only by the second stage.
	logic [W-1:0] meta_q;

	// Both stages shift on every edge.
	always_ff @(posedge clk) begin
		meta_q <= d;
		q <= meta_q;
	end
endmodule

// file: fmh_spi_tx.sv
// Transmit-only serial output running on the link clock.
module fmh_spi_tx (
	// Link clock and reset from the core domain.
	input wire logic linkClk,
	input wire logic reset,
	// Result word and modes from the core.
	fmh_link_if.link lnk,
	// Serial pins.
	input wire logic csIn,
	output logic sck,
	output logic mosi,
	output logic mosiOeN,
	output logic csOut,
	output logic csOeN
);
	import fmh_pkg::*;

	typedef enum logic {ST_IDLE, ST_SHIFT} fmh_spi_state_t;

	logic rstS, runS, pushS, togS, csS;
	logic tog_q;
	logic pending_q;
	logic [15:0] shadow_q;
	logic [15:0] shift_q;
	logic [4:0] bit_q;
	logic [2:0] div_q;
	fmh_spi_state_t state_q;
	logic newWord;
	logic halfDone;

	// Reset, run, push mode, word toggle and the select pin are synchronised; the word itself is not.
	fmh_sync #(.W(5)) uSync (
		.clk(linkClk),
		.d({reset, lnk.running, lnk.pushMode, lnk.wordToggle, csIn}),
		.q({rstS, runS, pushS, togS, csS})
	);

	assign newWord = togS != tog_q;
	assign halfDone = div_q == 3'(SCK_HALF - 1);

	// The word is settled long before its toggle arrives here, so it is safe to take.
	always_ff @(posedge linkClk) begin
		if (rstS) begin
			tog_q <= 1'b0;
			shadow_q <= 16'h0000;
		end else begin
			tog_q <= togS;
			if (newWord) shadow_q <= lnk.word;
		end
	end

	// Pending push frame; a new word wins over the clear at frame start.
	always_ff @(posedge linkClk) begin
		if (rstS) pending_q <= 1'b0;
		else if (newWord && runS && pushS) pending_q <= 1'b1;
		else if (state_q == ST_IDLE) pending_q <= 1'b0;
	end

	// Frame engine: the device divides its own clock for SCK in both modes.
	always_ff @(posedge linkClk) begin
		if (rstS) begin
			state_q <= ST_IDLE;
			sck <= 1'b0;
			mosi <= 1'b0;
			bit_q <= 5'h00;
			div_q <= 3'h0;
			shift_q <= 16'h0000;
		end else begin
			case (state_q)
				ST_IDLE: begin
					div_q <= 3'h0;
					bit_q <= 5'h00;
					sck <= 1'b0;
					// Nothing leaves unless measurement runs.
					if (runS && (pushS ? pending_q : !csS)) begin
						shift_q <= shadow_q;
						state_q <= ST_SHIFT;
					end
				end
				ST_SHIFT: begin
					div_q <= halfDone ? 3'h0 : div_q + 3'h1;
					if (halfDone) begin
						if (sck) sck <= 1'b0;
						else if (bit_q == 5'(WORD_BITS)) state_q <= ST_IDLE;
						else begin
							sck <= 1'b1;
							mosi <= shift_q[15];
							shift_q <= {shift_q[14:0], 1'b0};
							bit_q <= bit_q + 5'h01;
						end
					end
				end
				default: state_q <= ST_IDLE;
			endcase
		end
	end

	// Select is driven only in push mode; data floats when not in a frame.
	always_ff @(posedge linkClk) begin
		if (rstS) begin
			csOut <= 1'b1;
			csOeN <= 1'b1;
			mosiOeN <= 1'b1;
		end else begin
			csOeN <= !pushS;
			csOut <= !(state_q == ST_SHIFT);
			mosiOeN <= !(state_q == ST_SHIFT);
		end
	end
endmodule

// file: fmh_host_if.sv
// Command interpreter, measurement sequencer and serial ports of the flow meter.
module fmh_host_if #(
	parameter int SliceCycles = fmh_pkg::SLICE_CYC,
	parameter int TempCycles = fmh_pkg::TEMP_CYC,
	parameter int BaudDiv = fmh_pkg::BAUD_DIV
) (
	// Core clock and synchronous reset.
	input wire logic ref_clk,
	input wire logic reset,
	// Link clock for the synchronous output.
	input wire logic linkClk,
	// Asynchronous command port pins.
	input wire logic rxd,
	output logic txd,
	// Calibrated values from the measurement core.
	input wire logic [fmh_pkg::WORD_W-1:0] flowValue,
	input wire logic [fmh_pkg::WORD_W-1:0] tempValue,
	// Synchronous output pins.
	input wire logic csIn,
	output logic sck,
	output logic mosi,
	output logic mosiOeN,
	output logic csOut,
	output logic csOeN,
	// Status.
	output logic running,
	output logic tempUpdating,
	output logic [fmh_pkg::WORD_W-1:0] resultWord,
	output logic resultValid
);
	import fmh_pkg::*;

	localparam int BAUD_W = $clog2(BaudDiv);
	localparam int SLICE_W = $clog2(SliceCycles);
	localparam int TEMP_W = $clog2(TempCycles);

	typedef enum logic [3:0] {ACT_NONE, ACT_GO, ACT_GET, ACT_SPI, ACT_QTY, ACT_RES,
		ACT_INT, ACT_UPD, ACT_RD, ACT_WD, ACT_RESET} fmh_act_t;

	fmh_link_if lnk ();

	// Receiver state.
	logic rxS;
	logic rxBusy_q;
	logic [BAUD_W-1:0] rxCnt_q;
	logic [3:0] rxBit_q;
	logic [7:0] rxSh_q;
	logic rxStb_q;
	logic [7:0] rxByte_q;
	// Transmitter state and arbitration.
	logic [9:0] txSh_q;
	logic [3:0] txBit_q;
	logic [BAUD_W-1:0] txCnt_q;
	logic txLoad, respTake, measTake;
	logic [7:0] txByte;
	logic [7:0] echo_q;
	logic echoPend_q;
	// Line buffer and responses.
	logic [7:0] lineBuf_q [LINE_LEN];
	logic [3:0] lineLen_q;
	logic lineOvf_q;
	logic [7:0] respBuf_q [RESP_LEN];
	logic [3:0] respLen_q, respIdx_q;
	logic [7:0] respD [RESP_LEN];
	logic [3:0] respLenD;
	// Decode results.
	fmh_act_t dAct;
	logic [7:0] dErr, lastCh, slot;
	logic [7:0] pay [USER_BYTES];
	logic [2:0] payLen;
	logic [31:0] dInt;
	logic isTerm, exec, stopNow;
	// Settings; user bytes are kept apart and survive resets.
	logic getArm_q, updReq_q;
	fmh_spi_mode_t spiMode_q;
	fmh_qty_t qty_q;
	logic [2:0] res_q;
	logic [15:0] int_q;
	logic [8*USER_BYTES-1:0] userMem [SLOTS];
	// Measurement timing.
	logic [SLICE_W-1:0] sliceCnt_q;
	logic [7:0] periodCnt_q;
	logic [15:0] intCnt_q;
	logic [TEMP_W-1:0] tempCnt_q;
	logic sliceTick, periodEnd, tempStart, resultEvt;
	logic [1:0] measPend_q;
	logic tog_q;

	// Case folding lets keywords match in any case.
	function automatic logic [7:0] fold(input logic [7:0] c);
		fold = (c >= CH_A_LO && c <= CH_Z_LO) ? (c & ~CASE_BIT) : c;
	endfunction

	// Keyword match: extra 0 exact, 1 one argument, -1 a tail of one or more characters.
	function automatic logic isKey(input logic [8*LINE_LEN-1:0] k, input int extra);
		int n;
		n = 0;
		for (int i = 0; i < LINE_LEN; i++) if (k[8*i +: 8] != 8'h00) n = i + 1;
		isKey = (extra < 0) ? (int'(lineLen_q) > n) : (int'(lineLen_q) == n + extra);
		for (int i = 0; i < LINE_LEN; i++)
			if (i < n && fold(lineBuf_q[i]) != k[8*(n-1-i) +: 8]) isKey = 1'b0;
	endfunction

	// The receive pin is synchronised before anything looks at it.
	fmh_sync #(.W(1)) uRxSync (
		.clk(ref_clk),
		.d(rxd),
		.q(rxS)
	);

	// Receiver: start bit checked at mid-bit, then eight data bits and a stop bit.
	always_ff @(posedge ref_clk) begin
		rxStb_q <= 1'b0;
		if (reset) begin
			rxBusy_q <= 1'b0;
			rxCnt_q <= '0;
			rxBit_q <= 4'h0;
		end else if (!rxBusy_q) begin
			if (!rxS) begin
				rxBusy_q <= 1'b1;
				rxCnt_q <= BAUD_W'(BaudDiv / 2);
				rxBit_q <= 4'h0;
			end
		end else if (rxCnt_q != '0) begin
			rxCnt_q <= rxCnt_q - 1'b1;
		end else begin
			rxCnt_q <= BAUD_W'(BaudDiv - 1);
			rxBit_q <= rxBit_q + 4'h1;
			if (rxBit_q == 4'h0 && rxS) rxBusy_q <= 1'b0;
			else if (rxBit_q == 4'(RX_STOP_BIT)) begin
				rxBusy_q <= 1'b0;
				rxStb_q <= rxS;
				rxByte_q <= rxSh_q;
			end else rxSh_q <= {rxS, rxSh_q[7:1]};
		end
	end

	assign isTerm = rxByte_q == CH_LF || rxByte_q == CH_CR;
	assign exec = rxStb_q && isTerm && lineLen_q != 4'h0;
	assign stopNow = rxStb_q && fold(rxByte_q) == "S" && lineLen_q == 4'h0;
	assign lastCh = fold(lineBuf_q[lineLen_q - 4'h1]);
	assign slot = lineBuf_q[WD_SLOT_POS] - CH_0;

	// Line buffer; an empty terminator simply clears it.
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			lineLen_q <= 4'h0;
			lineOvf_q <= 1'b0;
		end else if (rxStb_q) begin
			if (isTerm || stopNow) begin
				lineLen_q <= 4'h0;
				lineOvf_q <= 1'b0;
			end else if (lineLen_q < 4'(LINE_LEN)) begin
				lineBuf_q[lineLen_q] <= rxByte_q;
				lineLen_q <= lineLen_q + 4'h1;
			end else lineOvf_q <= 1'b1;
		end
	end

	// Decoder, evaluated on the buffered line whenever a terminator arrives.
	always_comb begin
		logic tooBig;
		tooBig = 1'b0;
		dInt = 32'h0000_0000;
		dAct = ACT_NONE;
		dErr = ERR_NONE;
		payLen = 3'h0;
		for (int i = 0; i < USER_BYTES; i++) pay[i] = userMem[slot % SLOTS][8*(3-i) +: 8];
		for (int i = INT_ARG_POS; i < LINE_LEN; i++)
			if (i < int'(lineLen_q)) begin
				if (lineBuf_q[i] < CH_0 || lineBuf_q[i] > CH_9) tooBig = 1'b1;
				dInt = 32'(dInt * 32'd10 + 32'(lineBuf_q[i] - CH_0));
			end
		if (lineOvf_q) dErr = ERR_CMD;
		else if (isKey("GO", 0)) dAct = ACT_GO;
		else if (isKey("GET", 0)) dAct = ACT_GET;
		else if (isKey("UPDATETEMP", 0)) dAct = ACT_UPD;
		else if (isKey("RESET", 0)) dAct = ACT_RESET;
		else if (isKey("DEFSPI?", 0)) begin
			pay[0] = (spiMode_q == SPI_GET) ? "G" : "P";
			payLen = 3'h1;
		end else if (isKey("DEFSPI=", 1)) begin
			dAct = ACT_SPI;
			if (lastCh != "P" && lastCh != "G") dErr = ERR_RANGE;
		end else if (isKey("MOD?", 0)) begin
			pay[0] = (qty_q == QTY_TEMP) ? "T" : "F";
			payLen = 3'h1;
		end else if (isKey("MOD=", 1)) begin
			dAct = ACT_QTY;
			if (lastCh != "F" && lastCh != "T") dErr = ERR_RANGE;
		end else if (isKey("RES?", 0)) begin
			pay[0] = CH_0 + 8'(res_q);
			payLen = 3'h1;
		end else if (isKey("RES=", 1)) begin
			dAct = ACT_RES;
			if (lastCh < CH_0 || lastCh > CH_0 + 8'h07) dErr = ERR_RANGE;
		end else if (isKey("INT=", -1)) begin
			dAct = ACT_INT;
			if (tooBig || dInt > 32'(INT_MAX)) dErr = ERR_RANGE;
		end else if (isKey("RDATA", 1)) begin
			dAct = ACT_RD;
			payLen = 3'(USER_BYTES);
			if (lastCh < CH_0 || lastCh > CH_9) dErr = ERR_RANGE;
		end else if (isKey("WDATA", -1)) begin
			dAct = ACT_WD;
			if (slot >= 8'(SLOTS) || lineBuf_q[WD_SLOT_POS+1] != CH_EQ
				|| lineLen_q <= 4'(WD_DATA_POS)
				|| lineLen_q > 4'(WD_DATA_POS + USER_BYTES)) dErr = ERR_RANGE;
		end else dErr = ERR_CMD;
	end

	// Answer text: error line, or payload, line end and ok.
	always_comb begin
		logic [3:0] k;
		k = 4'h0;
		for (int i = 0; i < RESP_LEN; i++) respD[i] = 8'h00;
		if (exec && dErr != ERR_NONE) begin
			for (int i = 0; i < 7; i++) respD[i] = 8'("ERROR 0" >> (8 * (6 - i)));
			respD[7] = dErr;
			respD[8] = CH_CR;
			respD[9] = CH_LF;
			respLenD = 4'(RESP_LEN);
		end else begin
			if (exec && payLen != 3'h0) begin
				for (int i = 0; i < USER_BYTES; i++) if (i < int'(payLen)) respD[i] = pay[i];
				respD[payLen] = CH_CR;
				respD[payLen + 3'h1] = CH_LF;
				k = 4'(payLen) + 4'h2;
			end
			respD[k] = "o";
			respD[k + 4'h1] = "k";
			respD[k + 4'h2] = CH_CR;
			respD[k + 4'h3] = CH_LF;
			respLenD = k + 4'h4;
		end
	end

	// Response buffer, loaded when a command completes and drained by the transmitter.
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			respLen_q <= 4'h0;
			respIdx_q <= 4'h0;
		end else if (exec || stopNow) begin
			for (int i = 0; i < RESP_LEN; i++) respBuf_q[i] <= respD[i];
			respLen_q <= respLenD;
			respIdx_q <= 4'h0;
		end else if (respTake) respIdx_q <= respIdx_q + 4'h1;
	end

	// Settings and run state, changed by the command port; a result clears the single-measurement arm.
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			running <= 1'b0;
			getArm_q <= 1'b0;
			updReq_q <= 1'b0;
			spiMode_q <= SPI_PUSH;
			qty_q <= QTY_FLOW;
			res_q <= RES_DEFAULT;
			int_q <= INT_DEFAULT;
		end else begin
			updReq_q <= 1'b0;
			if (resultEvt) getArm_q <= 1'b0;
			if (stopNow) begin
				running <= 1'b0;
				getArm_q <= 1'b0;
			end else if (exec && dErr == ERR_NONE) begin
				case (dAct)
					ACT_GO: running <= 1'b1;
					ACT_GET: getArm_q <= 1'b1;
					ACT_SPI: spiMode_q <= (lastCh == "G") ? SPI_GET : SPI_PUSH;
					ACT_QTY: qty_q <= (lastCh == "T") ? QTY_TEMP : QTY_FLOW;
					ACT_RES: res_q <= 3'(lastCh - CH_0);
					ACT_INT: int_q <= 16'(dInt);
					ACT_UPD: updReq_q <= 1'b1;
					ACT_RESET: begin
						running <= 1'b0;
						getArm_q <= 1'b0;
					end
					default: ;
				endcase
			end
		end
	end

	// User byte store; unwritten bytes of a slot are cleared.
	always_ff @(posedge ref_clk) begin
		if (exec && dErr == ERR_NONE && dAct == ACT_WD) begin
			for (int i = 0; i < USER_BYTES; i++)
				userMem[slot % SLOTS][8*(3-i) +: 8] <= (i + WD_DATA_POS < int'(lineLen_q))
					? lineBuf_q[i + WD_DATA_POS] : 8'h00;
		end
	end

	assign sliceTick = sliceCnt_q == SLICE_W'(SliceCycles - 1);
	assign periodEnd = sliceTick && !tempUpdating
		&& periodCnt_q == 8'((8'h01 << res_q) - 8'h01);
	assign tempStart = !tempUpdating && (updReq_q
		|| (sliceTick && int_q != 16'h0000 && intCnt_q >= int_q - 16'h0001));
	assign resultEvt = periodEnd && (running || getArm_q);

	// Slice counter runs on; the result period is held while temperature is updated.
	always_ff @(posedge ref_clk) begin
		if (reset || sliceTick) sliceCnt_q <= '0;
		else sliceCnt_q <= sliceCnt_q + 1'b1;
		if (reset || periodEnd) periodCnt_q <= 8'h00;
		else if (sliceTick && !tempUpdating) periodCnt_q <= periodCnt_q + 8'h01;
	end

	// Temperature update interval and its fixed busy time.
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			intCnt_q <= 16'h0000;
			tempCnt_q <= '0;
			tempUpdating <= 1'b0;
		end else begin
			if (tempStart) intCnt_q <= 16'h0000;
			else if (sliceTick) intCnt_q <= intCnt_q + 16'h0001;
			if (tempStart) begin
				tempUpdating <= 1'b1;
				tempCnt_q <= '0;
			end else if (tempUpdating) begin
				tempCnt_q <= tempCnt_q + 1'b1;
				if (tempCnt_q == TEMP_W'(TempCycles - 1)) tempUpdating <= 1'b0;
			end
		end
	end

	// Result capture feeds both ports from the same event.
	always_ff @(posedge ref_clk) begin
		resultValid <= 1'b0;
		if (reset) begin
			resultWord <= 16'h0000;
			measPend_q <= 2'h0;
			tog_q <= 1'b0;
		end else if (resultEvt) begin
			resultWord <= (qty_q == QTY_TEMP) ? tempValue : flowValue;
			resultValid <= 1'b1;
			measPend_q <= 2'h2;
			tog_q <= !tog_q;
		end else if (measTake) measPend_q <= measPend_q - 2'h1;
	end

	assign lnk.word = resultWord;
	assign lnk.wordToggle = tog_q;
	assign lnk.pushMode = spiMode_q == SPI_PUSH;
	assign lnk.running = running;

	// Echo pending; a new character wins over the clear.
	always_ff @(posedge ref_clk) begin
		if (reset) echoPend_q <= 1'b0;
		else if (rxStb_q) begin
			echoPend_q <= 1'b1;
			echo_q <= rxByte_q;
		end else if (txLoad && !respTake && !measTake) echoPend_q <= 1'b0;
	end

	// Transmit arbitration: echo, then answer text, then measurement bytes.
	always_comb begin
		txByte = echo_q;
		txLoad = 1'b0;
		respTake = 1'b0;
		measTake = 1'b0;
		if (txBit_q == 4'h0) begin
			if (echoPend_q) txLoad = 1'b1;
			else if (respIdx_q != respLen_q) begin
				txLoad = 1'b1;
				respTake = 1'b1;
				txByte = respBuf_q[respIdx_q];
			end else if (measPend_q != 2'h0) begin
				txLoad = 1'b1;
				measTake = 1'b1;
				txByte = measPend_q[1] ? resultWord[15:8] : resultWord[7:0];
			end
		end
	end

	// Transmitter: start bit, eight data bits, then a full stop bit.
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			txd <= 1'b1;
			txBit_q <= 4'h0;
			txCnt_q <= '0;
		end else if (txBit_q == 4'h0) begin
			if (txLoad) begin
				txSh_q <= {1'b1, txByte, 1'b0};
				txBit_q <= 4'(UART_FRAME_BITS + 1);
				txCnt_q <= '0;
			end
		end else if (txCnt_q != '0) txCnt_q <= txCnt_q - 1'b1;
		else begin
			txd <= txSh_q[0];
			txSh_q <= {1'b1, txSh_q[9:1]};
			txCnt_q <= BAUD_W'(BaudDiv - 1);
			txBit_q <= txBit_q - 4'h1;
		end
	end

	// Link-side transmitter; it never reads a slave data pin.
	fmh_spi_tx uSpi (
		.linkClk(linkClk),
		.reset(reset),
		.lnk(lnk),
		.csIn(csIn),
		.sck(sck),
		.mosi(mosi),
		.mosiOeN(mosiOeN),
		.csOut(csOut),
		.csOeN(csOeN)
	);
endmodule

// file: fmh_host_if_props.sv
// Concurrent checks on the pins of the flow meter host interface.
module fmh_host_if_props (
	// Clocks and reset.
	input wire logic ref_clk,
	input wire logic reset,
	input wire logic linkClk,
	// Observed outputs.
	input wire logic txd,
	input wire logic sck,
	input wire logic mosi,
	input wire logic mosiOeN,
	input wire logic csOut,
	input wire logic csOeN,
	input wire logic running,
	input wire logic tempUpdating,
	input wire logic resultValid
);
	// Rising clock edges seen while chip select is low.
	logic sckPast_q;
	logic [4:0] edges_q;
	// The count clears whenever the select line is high.
	always_ff @(posedge linkClk) begin
		sckPast_q <= sck;
		edges_q <= csOut ? 5'h00 : edges_q + 5'(sck & ~sckPast_q);
	end
	// One clock high phase.
	sequence s_high_phase;
		sck [*4] ##1 !sck;
	endsequence
	// Lead-in from data enable to the first clock rise.
	sequence s_first_rise;
		!sck ##[1:6] sck;
	endsequence
	a_sck_high_time: assert property (@(posedge linkClk) disable iff (reset)
		$rose(sck) |-> s_high_phase) else $error("sck high phase wrong");
	a_frame_lead: assert property (@(posedge linkClk) disable iff (reset)
		$fell(mosiOeN) |-> s_first_rise) else $error("no first clock after enable");
	a_mosi_hold: assert property (@(posedge linkClk) disable iff (reset)
		$past(sck) |-> $stable(mosi)) else $error("mosi moved off a rising edge");
	a_idle_clock_low: assert property (@(posedge linkClk) disable iff (reset)
		mosiOeN |-> !sck) else $error("sck toggles while not driving");
	a_push_cs_pair: assert property (@(posedge linkClk) disable iff (reset)
		!csOeN |-> csOut == mosiOeN) else $error("select and data enable differ");
	a_push_sixteen: assert property (@(posedge linkClk) disable iff (reset)
		$rose(csOut) && !csOeN |-> edges_q == 5'h10) else $error("frame not 16 bits");
	a_reset_idle: assert property (@(posedge ref_clk) disable iff (reset)
		$fell(reset) |-> txd && !running && !resultValid) else $error("bad idle after reset");
	a_valid_pulse: assert property (@(posedge ref_clk) disable iff (reset)
		resultValid |=> !resultValid) else $error("result pulse too long");
	a_temp_freeze: assert property (@(posedge ref_clk) disable iff (reset)
		tempUpdating |-> !resultValid) else $error("result during temperature update");
endmodule

// file: fmh_spi_host_model.sv
// Host-side receiver of the synchronous output.
module fmh_spi_host_model (
	// Pins as seen on the wires.
	input wire logic sck,
	input wire logic mosi,
	input wire logic mosiOeN,
	input wire logic csN,
	// Last whole word and count of words.
	output logic [15:0] word,
	output int frames
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [15:0] shift = 16'h0000;
	logic lastBit = 1'b0;
	int bits = 0;
	// A floating data line reads inverted, so stale data never passes.
	wire line = mosiOeN ? ~lastBit : mosi;
	// The return data pin stays open and this model never drives sck.
	initial begin
		word = 16'h0000;
		frames = 0;
	end
	always @(mosi) if (!mosiOeN) lastBit = mosi;
	// Bits are taken after each falling edge, first bit the top one.
	always @(negedge sck or posedge csN) begin
		if (csN) begin
			bits = 0;
		end else begin
			shift = {shift[14:0], line};
			bits++;
			if (bits == 16) begin
				word = shift;
				frames++;
				bits = 0;
			end
		end
	end
endmodule

// file: fmh_host_if_tb.sv
// Self-checking bench of the flow meter host interface.
module fmh_host_if_tb;
	timeunit 1ns;
	timeprecision 1ps;
	import fmh_pkg::*;
	// Short slices give a result every few thousand cycles.
	localparam int Slice = 200;
	// A short bit time keeps the run brief; the protocol is the same at any rate.
	localparam int Baud = 64;
	logic ref_clk = 1'b0;
	logic linkClk = 1'b0;
	logic reset = 1'b1;
	logic rxd = 1'b1;
	logic hostCsN = 1'b1;
	logic [15:0] flowValue = 16'h0000;
	logic [15:0] tempValue = 16'h0000;
	logic [15:0] expWord, spiWord, resultWord;
	logic txd, sck, mosi, mosiOeN, csOut, csOeN, csWire, running, tempUpdating, resultValid;
	int n_fail = 0;
	int checks = 0;
	int seed = 32'hf9998a39;
	int spiFrames, n;
	logic [7:0] txq[$];
	always #2 ref_clk = ~ref_clk;
	// Offset keeps link edges clear of core edges.
	initial #1.3 forever #32 linkClk = ~linkClk;
	// Device drives select in push mode, else the host drives it directly.
	assign csWire = csOeN ? hostCsN : csOut;
	fmh_host_if #(.SliceCycles(Slice), .TempCycles(30), .BaudDiv(Baud))
		uut (.ref_clk(ref_clk),
		.reset(reset), .linkClk(linkClk), .rxd(rxd), .txd(txd), .flowValue(flowValue),
		.tempValue(tempValue), .csIn(csWire), .sck(sck), .mosi(mosi), .mosiOeN(mosiOeN),
		.csOut(csOut), .csOeN(csOeN), .running(running), .tempUpdating(tempUpdating),
		.resultWord(resultWord), .resultValid(resultValid));
	fmh_spi_host_model host (.sck(sck), .mosi(mosi), .mosiOeN(mosiOeN), .csN(csWire),
		.word(spiWord), .frames(spiFrames));
	task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
		checks++;
		if (seen !== exp) begin
			n_fail++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask
	// Sends text as 8N1 frames; settings only ever enter here.
	task automatic send(input string s);
		logic [9:0] f;
		for (int i = 0; i < s.len(); i++) begin
			f = {1'b1, s[i], 1'b0};
			for (int b = 0; b < 10; b++) begin
				rxd <= f[b];
				repeat (Baud) @(posedge ref_clk);
			end
		end
	endtask
	// Collects every byte sent on the command port.
	initial begin
		logic [7:0] c;
		forever begin
			@(negedge txd);
			repeat (Baud / 2) @(posedge ref_clk);
			for (int b = 0; b < 8; b++) begin
				repeat (Baud) @(posedge ref_clk);
				c[b] = txd;
			end
			txq.push_back(c);
		end
	end
	task automatic expect_tx(input string s);
		for (int w = 0; w < 20 * Baud * s.len() && txq.size() < s.len(); w++) @(posedge ref_clk);
		for (int i = 0; i < s.len(); i++) check("txd byte", 16'(txq.pop_front()), 16'(s[i]));
	endtask
	// Waits until the port has been quiet two bit times, then drops old bytes.
	task automatic idle_tx();
		int q;
		q = 0;
		for (int w = 0; w < 200 * Baud && q < 2 * Baud; w++) begin
			@(posedge ref_clk);
			q = txd ? q + 1 : 0;
		end
		txq.delete();
	endtask
	task automatic spi_quiet(input string what);
		repeat (2500) @(posedge ref_clk);
		n = spiFrames;
		repeat (5500) @(posedge ref_clk);
		check(what, 16'(spiFrames - n), 16'h0000);
	endtask
	task automatic finish_test();
		$display("checks %0d n_fail %0d", checks, n_fail);
		if (n_fail == 0 && checks > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask
	// Watchdog: about 30 command bytes and their replies plus the waits.
	initial begin
		repeat (150000) @(posedge ref_clk);
		n_fail++;
		finish_test();
	end
	initial begin
		repeat (10) @(posedge linkClk);
		@(negedge ref_clk);
		check("txd idle", 16'(txd), 16'h0001);
		check("sck idle", 16'(sck), 16'h0000);
		check("mosi enable", 16'(mosiOeN), 16'h0001);
		check("running", 16'(running), 16'h0000);
		@(posedge ref_clk);
		reset <= 1'b0;
		for (int p = 0; p < 3; p++) begin
			@(posedge ref_clk);
			expWord = 16'($random(seed));
			flowValue <= expWord;
			tempValue <= 16'($random(seed));
			if (p == 0) begin
				send("Go\r");
				expect_tx("Go\rok\r\n");
				check("running", 16'(running), 16'h0001);
				for (int w = 0; w < 20000 && txq.size() < 2; w++) @(posedge ref_clk);
				check("txd result", {txq[0], txq[1]}, expWord);
			end
			repeat (100) @(posedge ref_clk);
			for (int w = 0; w < 8000 && resultValid !== 1'b1; w++) @(negedge ref_clk);
			check("resultWord", resultWord, expWord);
			n = spiFrames;
			repeat (5000) @(posedge ref_clk);
			check("spi count", 16'(spiFrames - n), 16'h0001);
			check("spi word", spiWord, expWord);
		end
		send("s");
		@(negedge ref_clk);
		check("halted", 16'(running), 16'h0000);
		spi_quiet("spi halted");
		idle_tx();
		send("DefSpi=G\r");
		expect_tx("DefSpi=G\rok\r\n");
		send("defspi?\r");
		expect_tx("defspi?\rG\r\nok\r\n");
		send("res=8\r");
		expect_tx("res=8\rERROR 03\r\n");
		send("go\r");
		expect_tx("go\rok\r\n");
		check("cs enable", 16'(csOeN), 16'h0001);
		spi_quiet("spi unselected");
		hostCsN <= 1'b0;
		repeat (7000) @(posedge ref_clk);
		check("spi resend", 16'(spiFrames - n > 1), 16'h0001);
		check("spi get word", spiWord, expWord);
		hostCsN <= 1'b1;
		spi_quiet("spi released");
		finish_test();
	end
endmodule
bind fmh_host_if fmh_host_if_props chk (.ref_clk(ref_clk), .reset(reset), .linkClk(linkClk),
	.txd(txd), .sck(sck), .mosi(mosi), .mosiOeN(mosiOeN), .csOut(csOut), .csOeN(csOeN),
	.running(running), .tempUpdating(tempUpdating), .resultValid(resultValid));
